// file: include/serial_flash_map.svh
`ifndef SERIAL_FLASH_MAP_SVH
`define SERIAL_FLASH_MAP_SVH

// Instruction codes
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_READ 8'h03
`define OPC_FAST_READ 8'h0B
`define OPC_DUAL_READ 8'h3B
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_BLOCK_ERASE 8'hD8
`define OPC_HALF_BLOCK_ERASE 8'h52
`define OPC_SECTOR_ERASE 8'h20
`define OPC_CHIP_ERASE_A 8'hC7
`define OPC_CHIP_ERASE_B 8'h60
`define OPC_DEEP_SLEEP 8'hB9
`define OPC_WAKE 8'hAB

// Status register fields and reset value
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_LEVEL_LSB 2
`define ST_LEVEL_MSB 5
`define ST_LOCK_BIT 7
`define STATUS_RESET 8'h00

// Frame lengths and data starts in serial clock bits; page size in bytes
`define LEN_OPCODE 12'h008
`define LEN_STATUS_WRITE 12'h010
`define LEN_ADDR_CMD 12'h020
`define LEN_PROGRAM_MIN 12'h028
`define READ_DATA_START 12'h020
`define FAST_DATA_START 12'h028
`define PAGE_BYTES 9'h100

// Timing: figures in microseconds, counts derived from the clock period
`define CLK_PERIOD_NS 10
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define TPP_US 500
`define TSE_US 40000
`define TBE_US 250000
`define TCE_US 6000000
`define TW_US 10000
`define TPUW_US 1000

`endif

// file: include/serial_flash_pkg.sv
package serial_flash_pkg;

  // Internal self-timed operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_HALF_ERASE,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE,
    OP_STATUS_WRITE
  } op_kind_t;

  // Power states
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_ACTIVE,
    PWR_DEEP_SLEEP
  } pwr_t;

  // Status byte, msb first
  typedef struct packed {
    logic status_lock_bit;
    logic reserved;
    logic [3:0] protect_level;
    logic write_enable_latch;
    logic cycle_in_progress_flag;
  } status_t;

  // Request handed to the array
  typedef struct packed {
    op_kind_t kind;
    logic [23:0] addr;
    logic [8:0] len;
  } array_op_t;

endpackage

// file: rtl/serial_flash_control_protect.sv
`timescale 1ns/1ps
`include "serial_flash_map.svh"
module serial_flash_control_protect
  import serial_flash_pkg::*;
#(
  parameter int unsigned PP_CYC = `TPP_US * `CYC_PER_US,
  parameter int unsigned SE_CYC = `TSE_US * `CYC_PER_US,
  parameter int unsigned BE_CYC = `TBE_US * `CYC_PER_US,
  parameter int unsigned CE_CYC = `TCE_US * `CYC_PER_US,
  parameter int unsigned TW_CYC = `TW_US * `CYC_PER_US,
  parameter int unsigned PUW_CYC = `TPUW_US * `CYC_PER_US
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic serial_in_or_second_out_in,
  output logic serial_in_or_second_out_out,
  output logic serial_in_or_second_out_oe,
  output logic data_out,
  output logic data_out_oe,
  input wire logic wp_n,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] prog_idx,
  output logic [7:0] prog_byte,
  output array_op_t array_op,
  output logic op_start,
  output logic op_done,
  output status_t flash_status,
  output pwr_t power_state
);

  // Protect level to locked block, upper blocks first
  function automatic logic blk_locked(input logic [2:0] lvl, input logic [3:0] blk);
    case (lvl)
      3'h0: blk_locked = 1'b0;
      3'h1: blk_locked = (blk == 4'hF);
      3'h2: blk_locked = (blk >= 4'hE);
      3'h3: blk_locked = (blk >= 4'hC);
      3'h4: blk_locked = (blk >= 4'h8);
      default: blk_locked = 1'b1;
    endcase
  endfunction

  // Internal cycle length per operation, never below one cycle
  function automatic logic [31:0] cyc_len(input op_kind_t kind);
    case (kind)
      OP_PROGRAM: cyc_len = PP_CYC;
      OP_SECTOR_ERASE: cyc_len = SE_CYC;
      OP_HALF_ERASE: cyc_len = BE_CYC;
      OP_BLOCK_ERASE: cyc_len = BE_CYC;
      OP_CHIP_ERASE: cyc_len = CE_CYC;
      default: cyc_len = TW_CYC;
    endcase
    if (cyc_len == 32'h0000_0000) begin
      cyc_len = 32'h0000_0001;
    end
  endfunction

  // ---------------- Link domain (serial clock) ----------------
  logic [11:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] next_byte;
  logic [8:0] byte_idx;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] wdat_q;
  logic [8:0] dcnt_q;
  logic [11:0] nbits_q;
  logic seq_q = 1'b0;
  logic [7:0] page_mem [0:255];
  logic [17:0] lsync1_q;
  logic [17:0] lsync2_q;
  logic [7:0] stat_snap_q;
  logic [7:0] l_rd;
  status_t l_stat;
  logic l_ok;
  logic l_sleep;
  logic l_busy;
  logic ok_q;
  pwr_t pwr_q;

  assign next_byte = {shift_q[6:0], serial_in_or_second_out_in};
  assign byte_idx = bit_cnt_q[11:3];
  assign l_rd = lsync2_q[17:10];
  assign l_stat = lsync2_q[9:2];
  assign l_ok = lsync2_q[1];
  assign l_sleep = lsync2_q[0];
  assign l_busy = l_stat.cycle_in_progress_flag;

  // Device state into the link domain; first stage read only by the second
  always_ff @(posedge spi_clk) begin
    lsync1_q <= {rd_data, flash_status, ok_q, pwr_q == PWR_DEEP_SLEEP};
    lsync2_q <= lsync1_q;
  end

  // Bit counter restarts with every deselect
  // Msb-first input shift
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 12'h000;
      shift_q <= 8'h00;
    end else begin
      if (bit_cnt_q != 12'hFFF) begin
        bit_cnt_q <= bit_cnt_q + 12'h001;
      end
      shift_q <= next_byte;
    end
  end

  // Frame capture, left standing after deselect for the device side
  // Inputs taken on rising edges
  always_ff @(posedge spi_clk) begin
    nbits_q <= (bit_cnt_q == 12'hFFF) ? bit_cnt_q : bit_cnt_q + 12'h001;
    // A park-level change while deselected is no frame start
    if (bit_cnt_q == 12'h000 && !cs_n) begin
      seq_q <= ~seq_q;
      dcnt_q <= 9'h000;
    end
    if (bit_cnt_q[2:0] == 3'h7) begin
      case (byte_idx)
        9'h000: op_q <= next_byte;
        9'h001: begin
          addr_q[23:16] <= next_byte;
          wdat_q <= next_byte;
        end
        9'h002: addr_q[15:8] <= next_byte;
        9'h003: addr_q[7:0] <= next_byte;
        default: begin
          if (op_q == `OPC_PAGE_PROGRAM && !l_busy && dcnt_q != `PAGE_BYTES) begin
            page_mem[addr_q[7:0] + dcnt_q[7:0]] <= next_byte;
            dcnt_q <= dcnt_q + 9'h001;
          end
        end
      endcase
    end
  end

  // Output shifter on falling edges, released on deselect
  // Bit cycles falling to falling
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      data_out <= 1'b0;
      data_out_oe <= 1'b0;
      serial_in_or_second_out_out <= 1'b0;
      serial_in_or_second_out_oe <= 1'b0;
      stat_snap_q <= `STATUS_RESET;
    end else begin
      data_out_oe <= 1'b0;
      serial_in_or_second_out_oe <= 1'b0;
      if (l_ok && !l_sleep && bit_cnt_q >= `LEN_OPCODE) begin
        case (op_q)
          `OPC_STATUS_READ: begin
            // Fresh snapshot each byte so a poll sees the flag fall
            data_out_oe <= 1'b1;
            if (bit_cnt_q[2:0] == 3'h0) begin
              stat_snap_q <= l_stat;
              data_out <= l_stat[7];
            end else begin
              data_out <= stat_snap_q[~bit_cnt_q[2:0]];
            end
          end
          `OPC_READ, `OPC_FAST_READ: begin
            if (!l_busy && bit_cnt_q >= ((op_q == `OPC_READ) ? `READ_DATA_START
                                                           : `FAST_DATA_START)) begin
              data_out_oe <= 1'b1;
              data_out <= l_rd[~bit_cnt_q[2:0]];
            end
          end
          `OPC_DUAL_READ: begin
            // Odd bits on data_out, even on second line
            if (!l_busy && bit_cnt_q >= `FAST_DATA_START) begin
              data_out_oe <= 1'b1;
              serial_in_or_second_out_oe <= 1'b1;
              data_out <= l_rd[{~bit_cnt_q[1:0], 1'b1}];
              serial_in_or_second_out_out <= l_rd[{~bit_cnt_q[1:0], 1'b0}];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------- Device domain (ref_clk) ----------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic armed_q;
  logic seq_seen_q;
  logic [31:0] puw_cnt_q;
  logic busy_q;
  logic [31:0] cyc_cnt_q;
  logic wel_q;
  logic lock_q;
  logic [3:0] level_q;
  logic op_start_q;
  logic op_done_q;
  array_op_t array_op_q;
  logic [7:0] prog_byte_q;
  logic frame_end;
  logic cmd_valid;
  logic whole;
  logic puw_done;
  logic write_ok;
  logic status_locked;
  logic cyc_end;
  logic wel_set;
  logic wel_clr;
  logic sleep_go;
  logic wake_go;
  op_kind_t go_kind;

  // Pin synchronisers; cs_s3 stores the settled level for edges and for arming
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else if (clk_en) begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign frame_end = cs_s2_q && !cs_s3_q;
  // Frame words are static once deselect has settled; empty frames leave seq alone
  assign cmd_valid = frame_end && armed_q && ok_q && (seq_q != seq_seen_q);
  assign whole = (nbits_q[2:0] == 3'h0) && (nbits_q != 12'h000);
  assign puw_done = (puw_cnt_q == 32'h0000_0000);
  assign write_ok = whole && puw_done && wel_q;
  assign cyc_end = busy_q && (cyc_cnt_q == 32'h0000_0000);
  assign status_locked = lock_q && !wp_s2_q;

  // Arming, frame tracking and power-up delay
  // Deselect seen before first command
  // Nothing accepted until out of reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      seq_seen_q <= 1'b0;
      ok_q <= 1'b0;
      puw_cnt_q <= PUW_CYC;
    end else if (clk_en) begin
      ok_q <= 1'b1;
      if (cs_s2_q && cs_s3_q) begin
        armed_q <= 1'b1;
      end
      if (frame_end) begin
        seq_seen_q <= seq_q;
      end
      if (!puw_done) begin
        puw_cnt_q <= puw_cnt_q - 32'h0000_0001;
      end
    end
  end

  // Command acceptance
  always_comb begin
    wel_set = 1'b0;
    wel_clr = 1'b0;
    sleep_go = 1'b0;
    wake_go = 1'b0;
    go_kind = OP_NONE;
    if (cmd_valid) begin
      if (pwr_q == PWR_DEEP_SLEEP) begin
        wake_go = (op_q == `OPC_WAKE) && (nbits_q >= `LEN_OPCODE);
      end else if (!busy_q) begin
        case (op_q)
          `OPC_WRITE_ENABLE: wel_set = whole && puw_done;
          `OPC_WRITE_DISABLE: wel_clr = whole;
          `OPC_STATUS_WRITE: begin
            if (write_ok && nbits_q >= `LEN_STATUS_WRITE && !status_locked) begin
              go_kind = OP_STATUS_WRITE;
            end
          end
          `OPC_PAGE_PROGRAM: begin
            if (write_ok && nbits_q >= `LEN_PROGRAM_MIN &&
                !blk_locked(level_q[2:0], addr_q[19:16])) begin
              go_kind = OP_PROGRAM;
            end
          end
          `OPC_SECTOR_ERASE, `OPC_HALF_BLOCK_ERASE, `OPC_BLOCK_ERASE: begin
            if (write_ok && nbits_q >= `LEN_ADDR_CMD &&
                !blk_locked(level_q[2:0], addr_q[19:16])) begin
              go_kind = (op_q == `OPC_SECTOR_ERASE) ? OP_SECTOR_ERASE :
                        (op_q == `OPC_BLOCK_ERASE) ? OP_BLOCK_ERASE : OP_HALF_ERASE;
            end
          end
          `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B: begin
            // Whole-array erase refused while any block is protected
            if (write_ok && level_q[2:0] == 3'h0) begin
              go_kind = OP_CHIP_ERASE;
            end
          end
          `OPC_DEEP_SLEEP: sleep_go = whole;
          default: ;
        endcase
      end
    end
  end

  // Internal cycle timer and array request
  // Counter holds busy until expiry
  // Erase handed to array as region request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cyc_cnt_q <= 32'h0000_0000;
      op_start_q <= 1'b0;
      op_done_q <= 1'b0;
      array_op_q <= '{kind: OP_NONE, addr: 24'h00_0000, len: 9'h000};
    end else if (clk_en) begin
      op_start_q <= 1'b0;
      op_done_q <= 1'b0;
      if (go_kind != OP_NONE) begin
        busy_q <= 1'b1;
        cyc_cnt_q <= cyc_len(go_kind) - 32'h0000_0001;
        if (go_kind != OP_STATUS_WRITE) begin
          op_start_q <= 1'b1;
          array_op_q <= '{kind: go_kind, addr: addr_q, len: dcnt_q};
        end
      end else if (cyc_end) begin
        busy_q <= 1'b0;
        op_done_q <= 1'b1;
      end else if (busy_q) begin
        cyc_cnt_q <= cyc_cnt_q - 32'h0000_0001;
      end
    end
  end

  // Write enable latch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
    end else if (clk_en) begin
      if (wel_set) begin
        wel_q <= 1'b1;
      end else if (wel_clr || cyc_end) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Non-volatile bits held at factory default after reset
  // Protect level written
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_q <= 1'(`STATUS_RESET >> `ST_LOCK_BIT);
      level_q <= 4'h0;
    end else if (clk_en && go_kind == OP_STATUS_WRITE) begin
      lock_q <= wdat_q[`ST_LOCK_BIT];
      level_q <= wdat_q[`ST_LEVEL_MSB:`ST_LEVEL_LSB];
    end
  end

  // Power state
  // Active until cycle ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwr_q <= PWR_STANDBY;
    end else if (clk_en) begin
      case (pwr_q)
        PWR_DEEP_SLEEP: pwr_q <= wake_go ? PWR_STANDBY : PWR_DEEP_SLEEP;
        default: begin
          if (sleep_go) begin
            pwr_q <= PWR_DEEP_SLEEP;
          end else begin
            pwr_q <= (!cs_s2_q || busy_q || go_kind != OP_NONE) ? PWR_ACTIVE : PWR_STANDBY;
          end
        end
      endcase
    end
  end

  // Page buffer read port for the array; stable while busy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_byte_q <= 8'h00;
    end else if (clk_en) begin
      prog_byte_q <= page_mem[prog_idx];
    end
  end

  assign flash_status = '{status_lock_bit: lock_q, reserved: 1'b0, protect_level: level_q,
                          write_enable_latch: wel_q, cycle_in_progress_flag: busy_q};
  assign array_op = array_op_q;
  assign op_start = op_start_q;
  assign op_done = op_done_q;
  assign power_state = pwr_q;
  assign prog_byte = prog_byte_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd_in;
    cmd_valid && clk_en;
  endsequence

  sequence s_cycle_over;
    cyc_end && go_kind == OP_NONE && clk_en;
  endsequence

  sequence s_write_enable_cmd_ok;
    s_cmd_in ##0 (pwr_q != PWR_DEEP_SLEEP && !busy_q && op_q == `OPC_WRITE_ENABLE
                  && whole && puw_done);
  endsequence

  busy_start_a: assert property (op_start_q |-> busy_q)
    else $error("array request without busy");
  busy_end_a: assert property (s_cycle_over |=> !busy_q && op_done_q)
    else $error("busy not released at cycle end");
  wel_set_a: assert property (s_write_enable_cmd_ok |=> wel_q)
    else $error("write enable did not set latch");
  wel_clear_a: assert property (op_done_q |-> !wel_q)
    else $error("latch not cleared after cycle");
  busy_ignore_a: assert property (s_cmd_in ##0 (busy_q && cyc_cnt_q != 32'h0000_0000)
                                  |=> !op_start_q && $stable(level_q) && $stable(lock_q))
    else $error("command acted on while busy");
  powerup_wait_a: assert property (op_start_q |-> $past(puw_cnt_q) == 32'h0000_0000)
    else $error("write accepted in power-up delay");
  byte_bound_a: assert property (op_start_q |-> $past(nbits_q[2:0]) == 3'h0)
    else $error("partial byte command accepted");
  wel_needed_a: assert property (op_start_q |-> $past(wel_q))
    else $error("write without enable latch");
  status_lock_a: assert property (s_cmd_in ##0 (status_locked && op_q == `OPC_STATUS_WRITE)
                                  |=> $stable(level_q) && $stable(lock_q) && !busy_q)
    else $error("locked status register written");
  protect_hit_a: assert property (op_start_q && array_op_q.kind != OP_CHIP_ERASE
                                  |-> !blk_locked(level_q[2:0], array_op_q.addr[19:16]))
    else $error("protected block touched");
  sleep_hold_a: assert property (s_cmd_in ##0 (pwr_q == PWR_DEEP_SLEEP && op_q != `OPC_WAKE)
                                 |=> pwr_q == PWR_DEEP_SLEEP && !op_start_q)
    else $error("deep sleep left without wake");
  stay_active_a: assert property (busy_q && clk_en |=> pwr_q == PWR_ACTIVE)
    else $error("standby during internal cycle");

endmodule // serial_flash_control_protect

// file: tb/serial_flash_control_protect_test.sv
`timescale 1ns/1ps
module serial_flash_control_protect_test;
  import serial_flash_pkg::*;
  localparam int PUW = 300;
  logic ref_clk, rst_n, clk_en, wp_n, dio_out, dio_oe, data_out, data_out_oe, op_start, op_done;
  logic [7:0] rd_data, prog_idx, prog_byte, v;
  logic [23:0] addr;
  logic [7:0] q[$];
  logic [7:0] d[4];
  array_op_t array_op;
  status_t flash_status;
  pwr_t power_state;
  wire spi_clk, cs_n, mosi;
  wire dio_w = dio_oe ? dio_out : mosi;
  wire so_w = data_out_oe ? data_out : ref_clk;
  int num_errors, tests_run, starts, dones, s;
  bit dio_seen;
  integer seed;
  logic [3:0] lv[7] = '{4'h1, 4'h1, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5};
  logic [7:0] blk[7] = '{8'h0F, 8'h0E, 8'h0C, 8'h0B, 8'h08, 8'h07, 8'h00};
  int ok[7] = '{0, 1, 0, 1, 0, 1, 0};
  logic [7:0] eop[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  op_kind_t ekd[5] = '{OP_SECTOR_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE,
                       OP_CHIP_ERASE};

  serial_flash_control_protect #(.PP_CYC(600), .SE_CYC(40), .BE_CYC(40), .CE_CYC(40),
    .TW_CYC(40), .PUW_CYC(PUW)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .spi_clk(spi_clk), .cs_n(cs_n), .serial_in_or_second_out_in(dio_w),
    .serial_in_or_second_out_out(dio_out), .serial_in_or_second_out_oe(dio_oe),
    .data_out(data_out), .data_out_oe(data_out_oe), .wp_n(wp_n), .rd_data(rd_data),
    .prog_idx(prog_idx), .prog_byte(prog_byte), .array_op(array_op), .op_start(op_start),
    .op_done(op_done), .flash_status(flash_status), .power_state(power_state));

  spi_master_model m (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(so_w),
    .miso2(dio_w));

  // 100 MHz device clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Pulses are counted, since frames return after they pass
  always @(posedge ref_clk) begin
    if (op_start === 1'b1) starts++;
    if (op_done === 1'b1) dones++;
    if (cs_n === 1'b0 && dio_oe === 1'b1) dio_seen = 1'b1;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Random mode per frame exercises both clock parkings
  task automatic tx(input logic [7:0] b[$], input int tail = 0);
    @(negedge ref_clk);
    m.mode3 = 1'($random(seed));
    m.frame(b, tail);
  endtask

  task automatic wait_op;
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      if (flash_status.cycle_in_progress_flag === 1'b0) begin
        // One more edge so the end-of-cycle pulse is counted
        @(negedge ref_clk);
        return;
      end
    end
    num_errors++;
    $display("unexpected at %0t: busy never cleared", $time);
    give_verdict();
  endtask

  task automatic write_enable_cmd;
    tx('{8'h06});
  endtask

  task automatic ws(input logic [7:0] val, input bit done);
    write_enable_cmd();
    tx('{8'h01, val});
    if (done) wait_op();
  endtask

  // Main sequence
  initial begin
    seed = 32'hc658;
    rst_n = 1'b0;
    clk_en = 1'b1;
    wp_n = 1'b1;
    rd_data = 8'h00;
    prog_idx = 8'h00;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    chk(flash_status, 8'h00, "reset status");
    chk(power_state, PWR_STANDBY, "reset power");
    write_enable_cmd();
    chk(flash_status.write_enable_latch, 1'b0, "early enable");
    repeat (PUW) @(negedge ref_clk);
    write_enable_cmd();
    chk(flash_status.write_enable_latch, 1'b1, "enable");
    tx('{8'h05, 8'h00});
    chk(m.rx1, 8'h02, "status read");
    tx('{8'h04}, 3);
    chk(flash_status.write_enable_latch, 1'b1, "partial disable");
    tx('{8'h04});
    chk(flash_status.write_enable_latch, 1'b0, "disable");
    s = starts;
    tx('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55});
    chk(starts - s, 0, "program unlatched");
    write_enable_cmd();
    tx('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 4);
    chk(starts - s, 0, "program partial");
    // Random page program near a page end wraps the column
    addr = {4'h0, 12'($random(seed)), 8'hFE};
    q = '{8'h02, addr[23:16], addr[15:8], addr[7:0]};
    foreach (d[k]) begin
      d[k] = 8'($random(seed));
      q.push_back(d[k]);
    end
    write_enable_cmd();
    tx(q);
    chk(starts - s, 1, "program start");
    chk(array_op, {OP_PROGRAM, addr, 9'h004}, "program request");
    chk(flash_status.cycle_in_progress_flag, 1'b1, "busy");
    tx('{8'h04});
    chk(flash_status.write_enable_latch, 1'b1, "disable while busy");
    tx('{8'h05, 8'h00});
    chk(m.rx1[1:0], 2'b11, "status while busy");
    foreach (d[k]) begin
      @(negedge ref_clk);
      prog_idx = addr[7:0] + 8'(k);
      @(negedge ref_clk);
      chk(prog_byte, d[k], "page column");
    end
    // Clock enable low freezes the cycle timer well past its length
    clk_en = 1'b0;
    repeat (700) @(negedge ref_clk);
    chk(flash_status.cycle_in_progress_flag, 1'b1, "frozen busy");
    clk_en = 1'b1;
    wait_op();
    chk(flash_status[1:0], 2'b00, "program end");
    chk(dones, 1, "program done");
    v = 8'($random(seed)) & 8'h7F;
    ws(v, 1'b1);
    chk(flash_status, {2'b00, v[5:2], 2'b00}, "status write");
    // Protect levels with lock clear, so the low pin has no say
    wp_n = 1'b0;
    for (int i = 0; i < 7; i++) begin
      ws({2'b00, lv[i], 2'b00}, 1'b1);
      write_enable_cmd();
      s = starts;
      tx('{8'h20, blk[i], 8'h00, 8'h00});
      chk(starts - s, ok[i], "protect level");
      if (ok[i] == 1) wait_op();
    end
    ws(8'h00, 1'b1);
    foreach (eop[i]) begin
      q = '{eop[i]};
      if (i < 3) q = {q, 8'h01, 8'h00, 8'h00};
      write_enable_cmd();
      s = starts;
      tx(q);
      chk(starts - s, 1, "erase start");
      chk(array_op.kind, ekd[i], "erase kind");
      wait_op();
    end
    // Lock with low pin refuses, high pin allows
    ws(8'h80, 1'b1);
    ws(8'h84, 1'b0);
    chk(flash_status[7:2], 6'h20, "locked write");
    wp_n = 1'b1;
    tx('{8'h01, 8'h04});
    wait_op();
    chk(flash_status[7:2], 6'h01, "unlocked write");
    tx('{8'hB9});
    chk(power_state, PWR_DEEP_SLEEP, "deep sleep");
    write_enable_cmd();
    chk(flash_status.write_enable_latch, 1'b0, "sleep ignores");
    tx('{8'hAB});
    write_enable_cmd();
    chk(flash_status.write_enable_latch, 1'b1, "woken");
    // Reads: second line only for the dual command
    rd_data = 8'($random(seed));
    dio_seen = 1'b0;
    tx('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(m.rx1, rd_data, "single read");
    chk(dio_seen, 1'b0, "single lane");
    tx('{8'h3B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk({m.rx1[3], m.rx2[3], m.rx1[2], m.rx2[2], m.rx1[1], m.rx2[1], m.rx1[0], m.rx2[0]},
      rd_data, "dual read");
    chk(dio_seen, 1'b1, "dual lane");
    give_verdict();
  end
endmodule // serial_flash_control_protect_test

// file: tb/spi_master_model.sv
`timescale 1ns/1ps
// Bus master in mode 0 or 3; clock parks between frames
module spi_master_model (
  output logic spi_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso2
);
  logic [7:0] rx1;
  logic [7:0] rx2;
  bit mode3;

  // Idle: deselected, clock parked low
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mode3 = 1'b0;
  end

  task automatic frame(input logic [7:0] b[$], input int tail);
    int n;
    n = 8 * b.size() + tail;
    spi_clk = mode3;
    #27;
    cs_n = 1'b0;
    // Tail bits give a partial last byte
    for (int i = 0; i < n; i++) begin
      spi_clk = 1'b0;
      mosi = (i / 8 < b.size()) ? b[i / 8][7 - i % 8] : 1'b1;
      #40;
      spi_clk = 1'b1;
      rx1 = {rx1[6:0], miso};
      rx2 = {rx2[6:0], miso2};
      #40;
    end
    spi_clk = mode3;
    #20;
    cs_n = 1'b1;
    // Released line must not hold its last value
    mosi = ~mosi;
    #100;
  endtask
endmodule // spi_master_model
